// ==== core/pec_counters.sv ====
// Two programmable event counters with select registers and read port.
// Assumes events, privilege level and access requests are synchronous
// to clk_sys; reads are answered one cycle after the request.
// Overview of operation
// [RQ1] Low byte selects the event code
// [RQ2] Bits 8-15 qualify the chosen event
// [RQ3] User flag counts at privilege one-three
// [RQ4] Kernel flag counts at privilege zero
// [RQ5] Edge flag counts rising transitions only
// [RQ6] Pin pulses per event or on overflow
// [RQ7] Pin pulse lasts exactly one clock
// [RQ8] Interrupt flag raises request on overflow
// [RQ9] Select 0 bit 22 enables both counters
// [RQ10] Invert flag negates threshold comparison
// [RQ11] Nonzero threshold: add one when reached
// [RQ12] Zero threshold: add full event count
// [RQ13] Counter read gated by user read gate
// [RQ14] Counter read does not serialize
// [RQ15] Register access only at privilege zero
// [RQ16] Counter write sign-extends bit 31
// [RQ17] Counting starts right after enable write
// [RQ18] Clearing select stops its counter
// [RQ19] Two independent forty bit counters
// [RQ20] Duration mode counts clocks while true
// [RQ21] Overflow is carry out of bit 39
`timescale 1ns/1ps
module pec_counters (
    // Clock and reset
    input  wire logic                       clk_sys,
    input  wire logic                       sys_rst,
    // Processor context
    input  wire logic [1:0]                 privLevel,
    input  wire logic                       userReadGate,
    input  wire logic [1:0]                 durationMode,
    // Event inputs per channel
    input  wire pec_pkg::pec_evt_t [1:0]    evtIn,
    // Register access port
    input  wire logic                       msrWrite,
    input  wire logic                       msrRead,
    input  wire logic [1:0]                 msrIdx,
    input  wire logic [31:0]                msrWData,
    input  wire logic                       ctrRead,
    input  wire logic                       ctrIdx,
    output logic [pec_pkg::CNT_W-1:0]       rdData,
    output logic                            rdOk,
    output logic                            rdErr,
    output logic                            wrErr,
    // Outputs to pins and interrupt controller
    output logic [1:0]                      monitorOutputPin,
    output logic [1:0]                      ovfIrq
);

    pec_pkg::pec_state_t st_r;   // Registered state
    pec_pkg::pec_state_t st_nxt; // Next state
    logic [1:0]          qualOk; // Event and privilege qualified
    logic [1:0]          hit;    // Threshold or edge result
    logic [1:0]          incEn;  // Counter advances this cycle
    logic [1:0][pec_pkg::CNT_W:0] sum;   // Counter plus step with carry
    logic [1:0][pec_pkg::CNT_W-1:0] stepV; // Step to add
    logic                privZero; // Kernel privilege
    logic [1:0]          condQ;    // Qualified condition per channel

    assign privZero = (privLevel == 2'h0);

    // Per-channel qualify, threshold and step logic
    generate
        for (genvar i = 0; i < 2; i++) begin : g_ch
            logic [31:0] s;
            logic        priv;
            logic        match;
            logic        geq;
            logic        cond;
            assign s = st_r.sel[i];
            assign priv = (s[pec_pkg::SEL_USR_BIT] & !privZero) // see RQ3
                        | (s[pec_pkg::SEL_KRN_BIT] & privZero); // see RQ4
            // Code and qualifier must match the presented event
            assign match = (evtIn[i].code == s[7:0])             // see RQ1
                         && ((s[15:8] == 8'h00)
                             || ((evtIn[i].qual & s[15:8]) != 8'h00)); // see RQ2
            assign qualOk[i] = priv & match;
            // Threshold comparison, optionally negated
            assign geq = ({4'h0, evtIn[i].num} >= s[31:24]);
            assign cond = qualOk[i] & ((s[31:24] == 8'h00)
                        ? (evtIn[i].num != 4'h0)
                        : (geq ^ s[pec_pkg::SEL_INV_BIT])); // see RQ10
            // Edge history must follow the full condition, not the match
            assign condQ[i] = cond;                            // see RQ5
            // Edge mode takes only rising edges of the condition
            assign hit[i] = s[pec_pkg::SEL_EDGE_BIT]
                          ? (cond & !st_r.lastQ[i])            // see RQ5
                          : cond;
            // Enable from select 0 bit 22 gates both channels
            assign incEn[i] = hit[i] & st_r.sel[0][pec_pkg::SEL_EN_BIT]
                            & (s != 32'h0);     // see RQ9 see RQ17 see RQ18
            // Step: full count, one, or one clock in duration mode
            assign stepV[i] = (s[31:24] == 8'h00 && !durationMode[i]
                               && !s[pec_pkg::SEL_EDGE_BIT])
                ? {36'h0, evtIn[i].num}                         // see RQ12
                : 40'h00_0000_0001;              // see RQ11 see RQ20
            assign sum[i] = {1'b0, st_r.cnt[i]} + {1'b0, stepV[i]};
        end
    endgenerate

    // Next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.rdOk  = 1'b0;
        st_nxt.rdErr = 1'b0;
        st_nxt.wrErr = 1'b0;
        // Counting, pins and overflow requests per channel
        for (int i = 0; i < 2; i++) begin
            st_nxt.lastQ[i] = condQ[i];                         // see RQ5
            st_nxt.pin[i] = 1'b0;                               // see RQ7
            st_nxt.irq[i] = 1'b0;
            if (incEn[i]) begin
                st_nxt.cnt[i] = sum[i][pec_pkg::CNT_W-1:0];     // see RQ19
                // Carry out of top bit marks overflow
                if (sum[i][pec_pkg::CNT_W]) begin               // see RQ21
                    st_nxt.irq[i] = st_r.sel[i][pec_pkg::SEL_INT_BIT]; // see RQ8
                end
                st_nxt.pin[i] = st_r.sel[i][pec_pkg::SEL_PIN_BIT]
                              | sum[i][pec_pkg::CNT_W];         // see RQ6
            end
        end
        // Register writes, kernel only
        if (msrWrite) begin
            if (!privZero) begin
                st_nxt.wrErr = 1'b1;                            // see RQ15
            end else begin
                unique case (msrIdx)
                    pec_pkg::REG_SEL0: st_nxt.sel[0] = msrWData;
                    pec_pkg::REG_SEL1: st_nxt.sel[1] = msrWData;
                    pec_pkg::REG_CNT0:
                        st_nxt.cnt[0] = {{8{msrWData[31]}}, msrWData}; // see RQ16
                    pec_pkg::REG_CNT1:
                        st_nxt.cnt[1] = {{8{msrWData[31]}}, msrWData}; // see RQ16
                endcase
            end
        end
        // Register reads, kernel only
        if (msrRead) begin
            if (!privZero) begin
                st_nxt.rdErr = 1'b1;                            // see RQ15
            end else begin
                st_nxt.rdOk = 1'b1;
                unique case (msrIdx)
                    pec_pkg::REG_SEL0: st_nxt.rdData = {8'h00, st_r.sel[0]};
                    pec_pkg::REG_SEL1: st_nxt.rdData = {8'h00, st_r.sel[1]};
                    pec_pkg::REG_CNT0: st_nxt.rdData = st_r.cnt[0];
                    pec_pkg::REG_CNT1: st_nxt.rdData = st_r.cnt[1];
                endcase
            end
        end else if (ctrRead) begin
            // Counter read samples at once, no ordering wait
            if (userReadGate && !privZero) begin
                st_nxt.rdErr = 1'b1;                            // see RQ13
            end else begin
                st_nxt.rdOk = 1'b1;
                st_nxt.rdData = st_r.cnt[ctrIdx];               // see RQ14
            end
        end
    end

    // State register
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign rdData = st_r.rdData;
    assign rdOk = st_r.rdOk;
    assign rdErr = st_r.rdErr;
    assign wrErr = st_r.wrErr;
    assign monitorOutputPin = st_r.pin;
    assign ovfIrq = st_r.irq;

    // Pin never high without a fresh increment
    a_pin_one_pulse: assert property ( // see RQ7
        @(posedge clk_sys) disable iff (sys_rst)
        monitorOutputPin[0] |-> $past(incEn[0]))
        else $error("pin0 pulse without increment");

    // Same for the second channel pin
    a_pin_one_ch1: assert property ( // see RQ7
        @(posedge clk_sys) disable iff (sys_rst)
        monitorOutputPin[1] |-> $past(incEn[1]))
        else $error("pin1 pulse without increment");

    // Overflow request needs interrupt enable
    a_irq_needs_en: assert property ( // see RQ8
        @(posedge clk_sys) disable iff (sys_rst)
        ovfIrq[0] |-> $past(st_r.sel[0][pec_pkg::SEL_INT_BIT]))
        else $error("irq without enable");

    // Second channel request needs its own enable
    a_irq_ch1_en: assert property ( // see RQ8
        @(posedge clk_sys) disable iff (sys_rst)
        ovfIrq[1] |-> $past(st_r.sel[1][pec_pkg::SEL_INT_BIT]))
        else $error("irq1 without enable");

    // Request only follows a carry out of the top bit
    a_ovf_carry: assert property ( // see RQ21
        @(posedge clk_sys) disable iff (sys_rst)
        ovfIrq[0] |-> $past(sum[0][pec_pkg::CNT_W]))
        else $error("irq0 without carry");

    // Same carry rule on the second channel
    a_ovf_carry_ch1: assert property ( // see RQ21
        @(posedge clk_sys) disable iff (sys_rst)
        ovfIrq[1] |-> $past(sum[1][pec_pkg::CNT_W]))
        else $error("irq1 without carry");

    // No counting when global enable clear
    a_cnt_hold_off: assert property ( // see RQ9
        @(posedge clk_sys) disable iff (sys_rst)
        (!st_r.sel[0][pec_pkg::SEL_EN_BIT] && !msrWrite)
        |=> $stable(st_r.cnt[1]))
        else $error("counter moved while disabled");

    // Global enable gates the first counter as well
    a_cnt_hold_ch0: assert property ( // see RQ9
        @(posedge clk_sys) disable iff (sys_rst)
        (!st_r.sel[0][pec_pkg::SEL_EN_BIT] && !msrWrite)
        |=> $stable(st_r.cnt[0]))
        else $error("counter 0 moved while disabled");

    // Counter write sign-extends
    a_wr_sext: assert property ( // see RQ16
        @(posedge clk_sys) disable iff (sys_rst)
        (msrWrite && privZero && msrIdx == pec_pkg::REG_CNT0)
        |=> st_r.cnt[0][39:32] == {8{$past(msrWData[31])}})
        else $error("counter write not sign extended");

    // Second counter write sign-extends too
    a_wr_sext_ch1: assert property ( // see RQ16
        @(posedge clk_sys) disable iff (sys_rst)
        (msrWrite && privZero && msrIdx == pec_pkg::REG_CNT1)
        |=> st_r.cnt[1][39:32] == {8{$past(msrWData[31])}})
        else $error("counter 1 write not sign extended");

    // Kernel select write lands whole
    a_wr_lands: assert property ( // see RQ15
        @(posedge clk_sys) disable iff (sys_rst)
        (msrWrite && privZero && msrIdx == pec_pkg::REG_SEL1)
        |=> st_r.sel[1] == $past(msrWData))
        else $error("select write lost");

    // User write refused
    a_wr_priv: assert property ( // see RQ15
        @(posedge clk_sys) disable iff (sys_rst)
        (msrWrite && !privZero) |=> wrErr && $stable(st_r.sel))
        else $error("user write accepted");

    // No write error without a write
    a_wr_idle: assert property ( // see RQ15
        @(posedge clk_sys) disable iff (sys_rst)
        !msrWrite |=> !wrErr)
        else $error("write error without write");

    // User register read refused
    a_rd_priv: assert property ( // see RQ15
        @(posedge clk_sys) disable iff (sys_rst)
        (msrRead && !privZero) |=> rdErr && !rdOk)
        else $error("user register read accepted");

    // Gated counter read refused
    a_rd_gate: assert property ( // see RQ13
        @(posedge clk_sys) disable iff (sys_rst)
        (ctrRead && !msrRead && userReadGate && !privZero) |=> rdErr)
        else $error("gated read not refused");

    // Read answers in one cycle
    a_rd_latency: assert property ( // see RQ14
        @(posedge clk_sys) disable iff (sys_rst)
        (ctrRead && !userReadGate) |=> rdOk)
        else $error("counter read not answered");

    // No read verdict without a request
    a_rd_idle: assert property ( // see RQ14
        @(posedge clk_sys) disable iff (sys_rst)
        (!msrRead && !ctrRead) |=> !rdOk && !rdErr)
        else $error("read verdict without request");

    // Open counter read of channel 0, request step
    sequence s_ctr_req0;
        ctrRead && !msrRead && !userReadGate && !ctrIdx;
    endsequence

    // Sample is the count standing at the request edge
    a_ctr_sample: assert property ( // see RQ14
        @(posedge clk_sys) disable iff (sys_rst)
        s_ctr_req0 |=> rdOk && rdData == $past(st_r.cnt[0]))
        else $error("counter read sample wrong");

    // Edge mode holds the count while the condition stays high
    a_edge_once: assert property ( // see RQ5
        @(posedge clk_sys) disable iff (sys_rst)
        (st_r.sel[0][pec_pkg::SEL_EDGE_BIT] && st_r.lastQ[0] && !msrWrite)
        |=> $stable(st_r.cnt[0]))
        else $error("edge mode counted a held condition");

    // Nonzero threshold steps by exactly one
    a_thr_step: assert property ( // see RQ11
        @(posedge clk_sys) disable iff (sys_rst)
        (incEn[0] && st_r.sel[0][31:24] != 8'h00 && !msrWrite)
        |=> st_r.cnt[0] == $past(st_r.cnt[0]) + 40'h00_0000_0001)
        else $error("threshold step not one");

    // Zero threshold adds the whole event number
    a_zero_step: assert property ( // see RQ12
        @(posedge clk_sys) disable iff (sys_rst)
        (incEn[0] && st_r.sel[0][31:24] == 8'h00 && !durationMode[0]
         && !st_r.sel[0][pec_pkg::SEL_EDGE_BIT] && !msrWrite)
        |=> st_r.cnt[0] == $past(st_r.cnt[0])
                         + {36'h0, $past(evtIn[0].num)})
        else $error("zero threshold step wrong");

    // Zero select stops counter 1
    a_sel1_stop: assert property ( // see RQ18
        @(posedge clk_sys) disable iff (sys_rst)
        (st_r.sel[1] == 32'h0 && !msrWrite) |=> $stable(st_r.cnt[1]))
        else $error("counter 1 moved while cleared");

endmodule : pec_counters

// ==== core/pec_pkg.sv ====
// Package for the two-channel event counter block.
// Assumes one processor clock domain; shared by the counter top module.
package pec_pkg;

    // Select register field positions
    localparam int SEL_CODE_LO   = 0;     // Event code low bit
    localparam int SEL_QUAL_LO   = 8;     // Qualifier field low bit
    localparam int SEL_USR_BIT   = 16;    // User level flag
    localparam int SEL_KRN_BIT   = 17;    // Kernel level flag
    localparam int SEL_EDGE_BIT  = 18;    // Edge detect flag
    localparam int SEL_PIN_BIT   = 19;    // Pulse on event flag
    localparam int SEL_INT_BIT   = 20;    // Overflow interrupt enable
    localparam int SEL_EN_BIT    = 22;    // Global enable, select 0 only
    localparam int SEL_INV_BIT   = 23;    // Compare negate flag
    localparam int SEL_THR_LO    = 24;    // Threshold field low bit

    // Register indices on the access port
    localparam logic [1:0] REG_SEL0 = 2'h0;  // event_select_0
    localparam logic [1:0] REG_SEL1 = 2'h1;  // event_select_1
    localparam logic [1:0] REG_CNT0 = 2'h2;  // event_count_0
    localparam logic [1:0] REG_CNT1 = 2'h3;  // event_count_1

    // Widths and reset values
    localparam int CNT_W   = 40;           // Counter width
    localparam int EVN_W   = 4;            // Events per cycle width
    localparam logic [31:0] SEL_RST = 32'h0000_0000;  // Select after reset
    localparam logic [39:0] CNT_RST = 40'h00_0000_0000; // Count after reset

    // Per-channel event input group
    typedef struct packed {
        logic [7:0]       code;   // Event code being presented
        logic [EVN_W-1:0] num;    // Events this cycle for that code
        logic [7:0]       qual;   // Qualifier bits matching this event
    } pec_evt_t;

    // Whole register state of the block
    typedef struct packed {
        logic [1:0][31:0]      sel;     // Select registers
        logic [1:0][CNT_W-1:0] cnt;     // Counters
        logic [1:0]            lastQ;   // Previous qualified condition
        logic [1:0]            pin;     // Monitor output pins
        logic [1:0]            irq;     // Overflow requests
        logic [CNT_W-1:0]      rdData;  // Read data
        logic                  rdOk;    // Read accepted
        logic                  rdErr;   // Read refused
        logic                  wrErr;   // Write refused
    } pec_state_t;

endpackage : pec_pkg

// ==== sim/pec_counters_bench.sv ====
// Self-checking bench for the two-channel event counter block.
// Drives every port itself at the falling edge; one 40 MHz clock.
`timescale 1ns/1ps
module pec_counters_bench;
    // Clock, reset and processor context
    logic                    clk_sys      = 1'b0;
    logic                    sys_rst      = 1'b1;
    logic [1:0]              privLevel    = 2'h0;
    logic                    userReadGate = 1'b0;
    logic [1:0]              durationMode = 2'h0;
    pec_pkg::pec_evt_t [1:0] evtIn        = '0;
    // Access port
    logic                    msrWrite     = 1'b0;
    logic                    msrRead      = 1'b0;
    logic                    ctrRead      = 1'b0;
    logic                    ctrIdx       = 1'b0;
    logic [1:0]              msrIdx       = 2'h0;
    logic [31:0]             msrWData     = 32'h0;
    // Design outputs
    logic [39:0]             rdData;
    logic                    rdOk;
    logic                    rdErr;
    logic                    wrErr;
    logic [1:0]              monitorOutputPin;
    logic [1:0]              ovfIrq;
    int                      mismatches   = 0;
    int                      n_tests      = 0;
    int                      cycles       = 0;

    // Half period of 12.5 ns
    always #12.5 clk_sys = ~clk_sys;

    pec_counters pec_counters_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .privLevel(privLevel), .userReadGate(userReadGate),
        .durationMode(durationMode), .evtIn(evtIn), .msrWrite(msrWrite),
        .msrRead(msrRead), .msrIdx(msrIdx), .msrWData(msrWData),
        .ctrRead(ctrRead), .ctrIdx(ctrIdx), .rdData(rdData), .rdOk(rdOk),
        .rdErr(rdErr), .wrErr(wrErr), .monitorOutputPin(monitorOutputPin),
        .ovfIrq(ovfIrq));

    // Compare and count
    task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %h vs %h", $time, seen, exp);
        end
    endtask : chk

    // Counts, verdict and stop
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim

    // One request cycle: 0 write, 1 register read, 2 counter read
    task automatic acc(input int k, input logic [1:0] i,
                       input logic [31:0] d);
        @(negedge clk_sys);
        msrWrite = (k == 0);
        msrRead  = (k == 1);
        ctrRead  = (k == 2);
        msrIdx   = i;
        ctrIdx   = i[0];
        msrWData = d;
        @(negedge clk_sys);
        msrWrite = 1'b0;
        msrRead  = 1'b0;
        ctrRead  = 1'b0;
    endtask : acc

    // Write; refused only away from privilege zero
    task automatic wr(input logic [1:0] i, input logic [31:0] d);
        acc(0, i, d);
        chk({39'h0, wrErr}, {39'h0, privLevel != 2'h0});
    endtask : wr

    // Read of either kind with expected verdict and data
    task automatic rd(input int k, input logic [1:0] i,
                      input logic [39:0] e, input logic ok);
        acc(k, i, 32'h0);
        chk({38'h0, rdOk, rdErr}, {38'h0, ok, !ok});
        if (ok)
            chk(rdData, e);
    endtask : rd

    // Events on both channels for c cycles
    task automatic ev(input logic [3:0] n, input int c);
        @(negedge clk_sys);
        evtIn[0].num = n;
        evtIn[1].num = n;
        repeat (c) @(negedge clk_sys);
        evtIn[0].num = 4'h0;
        evtIn[1].num = 4'h0;
    endtask : ev

    // Single channel 0 event, then pins and requests one cycle later
    task automatic one(input logic [1:0] p, input logic [1:0] q);
        evtIn[0].num = 4'h1;
        @(negedge clk_sys);
        evtIn[0].num = 4'h0;
        chk({36'h0, monitorOutputPin, ovfIrq}, {36'h0, p, q});
        @(negedge clk_sys);
        chk({36'h0, monitorOutputPin, ovfIrq}, 40'h0);
    endtask : one

    // Hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            end_sim();
        end
    end

    // Main sequence
    initial begin
        evtIn[0].code = 8'h05;
        evtIn[1].code = 8'h05;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        sys_rst = 1'b0;
        rd(1, 2'h0, 40'h0, 1'b1);
        wr(2'h2, 32'h8000_0000);
        rd(1, 2'h2, 40'hFF_8000_0000, 1'b1);
        wr(2'h3, 32'h7FFF_FFFF);
        rd(1, 2'h3, 40'h00_7FFF_FFFF, 1'b1);
        privLevel = 2'h3;
        wr(2'h2, 32'h0);
        rd(1, 2'h2, 40'h0, 1'b0);
        rd(2, 2'h0, 40'hFF_8000_0000, 1'b1);
        userReadGate = 1'b1;
        rd(2, 2'h0, 40'h0, 1'b0);
        privLevel = 2'h0;
        rd(2, 2'h1, 40'h00_7FFF_FFFF, 1'b1);
        userReadGate = 1'b0;
        wr(2'h2, 32'h0);
        wr(2'h3, 32'h0);
        wr(2'h1, 32'h0002_0005);
        ev(4'h3, 1);
        rd(1, 2'h3, 40'h0, 1'b1);
        wr(2'h0, 32'h0041_0005);
        ev(4'h3, 1);
        ev(4'h2, 1);
        rd(1, 2'h2, 40'h0, 1'b1);
        rd(1, 2'h3, 40'h5, 1'b1);
        privLevel = 2'h1;
        ev(4'h1, 1);
        privLevel = 2'h0;
        rd(1, 2'h2, 40'h1, 1'b1);
        rd(1, 2'h3, 40'h5, 1'b1);
        wr(2'h0, 32'h0243_0005);
        wr(2'h2, 32'h0);
        ev(4'h1, 1);
        ev(4'h2, 1);
        ev(4'h3, 1);
        rd(1, 2'h2, 40'h2, 1'b1);
        evtIn[0].num = 4'h2;
        wr(2'h0, 32'h02C3_0005);
        wr(2'h2, 32'h0);
        rd(1, 2'h2, 40'h0, 1'b1);
        evtIn[0].num = 4'h1;
        rd(1, 2'h2, 40'h1, 1'b1);
        evtIn[0].num = 4'h2;
        wr(2'h0, 32'h0047_0005);
        evtIn[0].num = 4'h0;
        wr(2'h2, 32'h0);
        ev(4'h1, 3);
        ev(4'h1, 2);
        rd(1, 2'h2, 40'h2, 1'b1);
        wr(2'h0, 32'h0043_0005);
        wr(2'h2, 32'h0);
        durationMode = 2'h1;
        ev(4'h3, 4);
        durationMode = 2'h0;
        rd(1, 2'h2, 40'h4, 1'b1);
        wr(2'h0, 32'h005B_0005);
        wr(2'h2, 32'hFFFF_FFFF);
        one(2'h1, 2'h1);
        rd(1, 2'h2, 40'h0, 1'b1);
        one(2'h1, 2'h0);
        wr(2'h0, 32'h0043_0005);
        one(2'h0, 2'h0);
        wr(2'h0, 32'h0043_0105);
        wr(2'h2, 32'h0);
        ev(4'h1, 1);
        rd(1, 2'h2, 40'h0, 1'b1);
        evtIn[0].qual = 8'h01;
        ev(4'h1, 1);
        rd(1, 2'h2, 40'h1, 1'b1);
        wr(2'h0, 32'h0043_0106);
        ev(4'h1, 1);
        rd(1, 2'h2, 40'h1, 1'b1);
        wr(2'h1, 32'h0);
        wr(2'h3, 32'h0);
        ev(4'h1, 2);
        rd(1, 2'h3, 40'h0, 1'b1);
        wr(2'h1, 32'h0003_0005);
        wr(2'h0, 32'h0003_0005);
        wr(2'h2, 32'h0);
        ev(4'h1, 2);
        rd(1, 2'h2, 40'h0, 1'b1);
        rd(1, 2'h3, 40'h0, 1'b1);
        end_sim();
    end
endmodule : pec_counters_bench
